/* core/i2cra_core.sv */
`timescale 1ns/10ps
module i2cra_core #(
    parameter int HALF_UNIT = i2cra_pkg::HALF_UNIT_CYC // cycles per half-period step
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_n_out,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n_out
);
    // half period must fit the 12-bit timer for every divider setting
    generate
        if (HALF_UNIT < 1 || HALF_UNIT > 127) begin : g_bad_unit
            $error("HALF_UNIT out of range 1..127");
        end
    endgenerate

    // address hit, shared by the write and read decoders
    function automatic logic hit(input logic [2:0] a, input logic [2:0] sel);
        hit = (a == sel);
    endfunction : hit

    // pin synchronisers and one extra stage for edge finding
    logic scl_s1_r, scl_s2_r, scl_d_r;
    logic sda_s1_r, sda_s2_r, sda_d_r;
    // software visible registers
    logic [7:0] shift_r, slave_r, ctrl_r, clkc_r;
    logic [3:0] portsel_r; // upper nibble not stored
    i2cra_pkg::i2cra_status_t status_r;
    logic ack_phase_r; // ninth clock of the byte
    logic [7:0] rdata_r;
    // master sequencer
    i2cra_pkg::i2cra_mstate_t mst_state_r, mst_state_nxt;
    logic [11:0] cnt_r, cnt_nxt;
    logic [1:0] phase_r, phase_nxt;
    logic [3:0] falls_r, falls_nxt;
    logic scl_oe_n_r, scl_oe_n_nxt; // low = pulling scl low
    logic sda_oe_n_r, sda_oe_n_nxt; // low = pulling sda low
    logic pin_lvl_r; // open drain: driven level is always zero

    // bus condition detection on synchronised levels
    wire scl_rise = scl_s2_r & ~scl_d_r;
    wire scl_hi = scl_s2_r & scl_d_r;
    wire start_det = scl_hi & sda_d_r & ~sda_s2_r;
    wire stop_det = scl_hi & ~sda_d_r & sda_s2_r;
    // write and read decode
    wire wr_shift = wr_in & hit(addr_in, i2cra_pkg::ADDR_SHIFT);
    wire wr_slave = wr_in & hit(addr_in, i2cra_pkg::ADDR_SLAVE);
    wire wr_status = wr_in & hit(addr_in, i2cra_pkg::ADDR_STATUS);
    wire wr_ctrl = wr_in & hit(addr_in, i2cra_pkg::ADDR_CONTROL);
    wire wr_clock = wr_in & hit(addr_in, i2cra_pkg::ADDR_CLOCK);
    wire wr_portsel = wr_in & hit(addr_in, i2cra_pkg::ADDR_PORTSEL);
    wire wr_txbuf = wr_in & hit(addr_in, i2cra_pkg::ADDR_TXBUF);
    wire i2cra_pkg::i2cra_status_t wstat = wdata_in;
    wire enable = ctrl_r[i2cra_pkg::CTRL_ENABLE_BIT];
    wire [2:0] bitcnt = ctrl_r[2:0];
    // start from an idle free bus, or restart while holding as master
    wire start_ok = (mst_state_r == i2cra_pkg::M_IDLE) ? ~status_r.bb
                  : (mst_state_r == i2cra_pkg::M_HOLD);
    wire start_trig = wr_status & enable & wstat.master_select & wstat.transmit_direction & wstat.bb & start_ok;
    wire stop_trig = wr_status & enable & wstat.master_select & wstat.transmit_direction & ~wstat.bb
                   & (mst_state_r == i2cra_pkg::M_HOLD);
    wire byte_done = scl_rise & ack_phase_r;
    // rises made while generating a start or stop are not data bits
    wire bit_in = scl_rise & ~ack_phase_r & ~start_det
                & (mst_state_r != i2cra_pkg::M_START) & (mst_state_r != i2cra_pkg::M_STOP);
    // timer reload and tick; any released scl phase waits while scl is still held low
    wire [11:0] half_w = 12'((int'(clkc_r[i2cra_pkg::CLOCK_DIV_MSB:0]) + 1) * HALF_UNIT);
    wire stretch = scl_oe_n_r & ~scl_s2_r & (mst_state_r != i2cra_pkg::M_IDLE);
    wire tick = (cnt_r == 12'h000) & ~stretch;
    // read selection; transmit buffer and upper port bits read as zero
    wire [7:0] rd_mux =
        hit(addr_in, i2cra_pkg::ADDR_SHIFT) ? shift_r :
        hit(addr_in, i2cra_pkg::ADDR_SLAVE) ? slave_r :
        hit(addr_in, i2cra_pkg::ADDR_STATUS) ? 8'(status_r) :
        hit(addr_in, i2cra_pkg::ADDR_CONTROL) ? ctrl_r :
        hit(addr_in, i2cra_pkg::ADDR_CLOCK) ? clkc_r :
        hit(addr_in, i2cra_pkg::ADDR_PORTSEL) ? {4'h0, portsel_r} :
        8'h00;

    // two-flop synchronisers; first stage read only by the second
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            {scl_s1_r, scl_s2_r, scl_d_r} <= 3'h7;
            {sda_s1_r, sda_s2_r, sda_d_r} <= 3'h7;
        end else begin
            {scl_s1_r, scl_s2_r, scl_d_r} <= {scl_in, scl_s1_r, scl_s2_r};
            {sda_s1_r, sda_s2_r, sda_d_r} <= {sda_in, sda_s1_r, sda_s2_r};
        end
    end

    // read data valid in the cycle after the strobe only; reads change nothing
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rd_in ? rd_mux : 8'h00;
        end
    end

    // plain software registers, never touched by hardware
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            clkc_r <= i2cra_pkg::RST_ZERO;
            portsel_r <= 4'h0;
        end else begin
            if (wr_clock) clkc_r <= wdata_in;
            if (wr_portsel) portsel_r <= wdata_in[i2cra_pkg::PORTSEL_MSB:0];
        end
    end

    // slave address: hardware clear at stop beats a same-cycle write
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            slave_r <= i2cra_pkg::RST_ZERO;
        end else begin
            if (wr_slave) slave_r <= wdata_in;
            if (stop_det) slave_r[i2cra_pkg::SLAVE_RW_BIT] <= 1'b0;
        end
    end

    // control: bit counter owned by hardware on bus events
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_r <= i2cra_pkg::RST_ZERO;
            ack_phase_r <= 1'b0;
        end else begin
            if (wr_ctrl) ctrl_r <= wdata_in;
            if (start_det) begin
                ctrl_r[2:0] <= 3'h0;
                ack_phase_r <= 1'b0;
            end else if (bit_in) begin
                ctrl_r[2:0] <= 3'(bitcnt + 3'h1);
                ack_phase_r <= (bitcnt == 3'(i2cra_pkg::LAST_BIT));
            end else if (byte_done) begin
                ack_phase_r <= 1'b0;
            end
        end
    end

    // shift register: software write wins, buffer write forwards into it
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shift_r <= i2cra_pkg::RST_ZERO;
        end else if (wr_shift || wr_txbuf) begin
            shift_r <= wdata_in;
        end else if (bit_in) begin
            shift_r <= {shift_r[6:0], sda_s2_r};
        end
    end

    // status: busy follows the bus; byte end clears pin over any write
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_r <= i2cra_pkg::i2cra_status_t'(i2cra_pkg::RST_STATUS);
        end else begin
            if (wr_status) begin
                status_r.master_select <= wstat.master_select;
                status_r.transmit_direction <= wstat.transmit_direction;
                status_r.pin <= wstat.pin;
            end
            if (wr_shift) status_r.pin <= 1'b1;
            if (start_det) status_r.bb <= 1'b1;
            if (stop_det) begin
                status_r.bb <= 1'b0;
                status_r.master_select <= 1'b0;
                status_r.transmit_direction <= 1'b0;
            end
            if (byte_done) begin
                status_r.pin <= 1'b0;
                status_r.lrb <= sda_s2_r;
            end
        end
    end

    // master sequencer next state
    always_comb begin
        mst_state_nxt = mst_state_r;
        cnt_nxt = (cnt_r == 12'h000 || stretch) ? cnt_r : 12'(cnt_r - 12'h001);
        phase_nxt = phase_r;
        falls_nxt = falls_r;
        scl_oe_n_nxt = scl_oe_n_r;
        sda_oe_n_nxt = sda_oe_n_r;
        case (mst_state_r)
            i2cra_pkg::M_IDLE: begin
                scl_oe_n_nxt = 1'b1;
                sda_oe_n_nxt = 1'b1;
                if (start_trig) begin
                    mst_state_nxt = i2cra_pkg::M_START;
                    phase_nxt = 2'h0;
                    cnt_nxt = half_w;
                end
            end
            i2cra_pkg::M_START: begin
                // release sda, release scl, pull sda, pull scl
                if (tick) begin
                    cnt_nxt = half_w;
                    phase_nxt = 2'(phase_r + 2'h1);
                    case (phase_r)
                        2'h0: sda_oe_n_nxt = 1'b1;
                        2'h1: scl_oe_n_nxt = 1'b1;
                        2'h2: sda_oe_n_nxt = 1'b0;
                        default: begin
                            scl_oe_n_nxt = 1'b0;
                            falls_nxt = 4'h0;
                            mst_state_nxt = i2cra_pkg::M_RUN;
                        end
                    endcase
                end
            end
            i2cra_pkg::M_RUN: begin
                // data moves only while scl is low, never under a high clock
                if (!scl_oe_n_r) sda_oe_n_nxt = ~(status_r.transmit_direction & ~ack_phase_r & ~shift_r[7]);
                if (tick) begin
                    cnt_nxt = half_w;
                    scl_oe_n_nxt = ~scl_oe_n_r;
                    if (scl_oe_n_r) begin
                        falls_nxt = 4'(falls_r + 4'h1);
                        if (falls_r == 4'(i2cra_pkg::LAST_FALL)) mst_state_nxt = i2cra_pkg::M_HOLD;
                    end
                end
            end
            i2cra_pkg::M_HOLD: begin
                // scl held low until software decides
                if (start_trig) begin
                    mst_state_nxt = i2cra_pkg::M_START;
                    phase_nxt = 2'h0;
                    cnt_nxt = half_w;
                end else if (stop_trig) begin
                    mst_state_nxt = i2cra_pkg::M_STOP;
                    phase_nxt = 2'h0;
                    cnt_nxt = half_w;
                end else if (wr_shift) begin
                    mst_state_nxt = i2cra_pkg::M_RUN;
                    falls_nxt = 4'h0;
                    cnt_nxt = half_w;
                end
            end
            i2cra_pkg::M_STOP: begin
                // pull sda, release scl, release sda
                if (tick) begin
                    cnt_nxt = half_w;
                    phase_nxt = 2'(phase_r + 2'h1);
                    case (phase_r)
                        2'h0: sda_oe_n_nxt = 1'b0;
                        2'h1: scl_oe_n_nxt = 1'b1;
                        default: begin
                            sda_oe_n_nxt = 1'b1;
                            mst_state_nxt = i2cra_pkg::M_IDLE;
                        end
                    endcase
                end
            end
            default: mst_state_nxt = i2cra_pkg::M_IDLE;
        endcase
        // disabling the interface drops the bus at once
        if (!enable) begin
            mst_state_nxt = i2cra_pkg::M_IDLE;
            scl_oe_n_nxt = 1'b1;
            sda_oe_n_nxt = 1'b1;
        end
    end

    // master sequencer registers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mst_state_r <= i2cra_pkg::M_IDLE;
            cnt_r <= 12'h000;
            phase_r <= 2'h0;
            falls_r <= 4'h0;
            scl_oe_n_r <= 1'b1;
            sda_oe_n_r <= 1'b1;
            pin_lvl_r <= 1'b0;
        end else begin
            mst_state_r <= mst_state_nxt;
            cnt_r <= cnt_nxt;
            phase_r <= phase_nxt;
            falls_r <= falls_nxt;
            scl_oe_n_r <= scl_oe_n_nxt;
            sda_oe_n_r <= sda_oe_n_nxt;
            pin_lvl_r <= 1'b0;
        end
    end

    assign rdata_out = rdata_r;
    assign scl_out = pin_lvl_r;
    assign sda_out = pin_lvl_r;
    assign scl_oe_n_out = scl_oe_n_r;
    assign sda_oe_n_out = sda_oe_n_r;

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    a_rbw_stop_clear: assert property (stop_det |=> !slave_r[i2cra_pkg::SLAVE_RW_BIT])
        else $error("read/write match bit not cleared at stop");
    a_bitcnt_start: assert property (start_det |=> ctrl_r[2:0] == 3'h0)
        else $error("bit counter not reset at start");
    a_bitcnt_step: assert property (bit_in && !wr_ctrl |=> ctrl_r[2:0] == 3'($past(bitcnt) + 3'h1))
        else $error("bit counter did not advance");
    a_clock_readback: assert property (wr_clock ##1 (rd_in && hit(addr_in, i2cra_pkg::ADDR_CLOCK))
        |=> rdata_out == $past(wdata_in, 2))
        else $error("clock control read back differs");
    a_portsel_upper: assert property (rd_in && hit(addr_in, i2cra_pkg::ADDR_PORTSEL)
        |=> rdata_out[7:4] == 4'h0)
        else $error("port select upper bits not zero");
    a_txbuf_read: assert property (rd_in && hit(addr_in, i2cra_pkg::ADDR_TXBUF) |=> rdata_out == 8'h00)
        else $error("transmit buffer readable");
    a_txbuf_forward: assert property (wr_txbuf |=> shift_r == $past(wdata_in))
        else $error("buffer write not forwarded");
    a_read_no_effect: assert property (rd_in && mst_state_r == i2cra_pkg::M_STOP && !tick && enable
        |=> mst_state_r == i2cra_pkg::M_STOP && $stable(phase_r))
        else $error("read disturbed stop generation");
    a_stop_trigger: assert property (stop_trig |=> mst_state_r == i2cra_pkg::M_STOP ##1 !scl_oe_n_r)
        else $error("stop write did not start stop");
    a_busy_follow: assert property (start_det |=> status_r.bb)
        else $error("busy not set at start");
    a_busy_clear: assert property (stop_det |=> !status_r.bb)
        else $error("busy not cleared at stop");

    c_start_gen: cover property (start_trig ##[1:1000] start_det);
    c_byte_done: cover property (byte_done ##1 !status_r.pin);
    c_stop_gen: cover property (stop_trig ##[1:1000] stop_det);
endmodule : i2cra_core

/* core/i2cra_pkg.sv */
package i2cra_pkg;
    // register indices on the byte-wide register port
    localparam logic [2:0] ADDR_SHIFT = 3'h0;
    localparam logic [2:0] ADDR_SLAVE = 3'h1;
    localparam logic [2:0] ADDR_STATUS = 3'h2;
    localparam logic [2:0] ADDR_CONTROL = 3'h3;
    localparam logic [2:0] ADDR_CLOCK = 3'h4;
    localparam logic [2:0] ADDR_PORTSEL = 3'h5;
    localparam logic [2:0] ADDR_TXBUF = 3'h6;
    // reset values
    localparam logic [7:0] RST_STATUS = 8'h10;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // field positions
    localparam int CTRL_ENABLE_BIT = 3;
    localparam int SLAVE_RW_BIT = 0;
    localparam int CLOCK_DIV_MSB = 4;
    localparam int PORTSEL_MSB = 3;
    // timing: one scl half period unit, least time, rounded up
    localparam int CLK_PERIOD_NS = 5;
    localparam int HALF_UNIT_NS = 250;
    localparam int HALF_UNIT_CYC = (HALF_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LAST_BIT = 7;
    localparam int LAST_FALL = 8;
    // status register layout, bit 7 first
    typedef struct packed {
        logic master_select;
        logic transmit_direction;
        logic bb;
        logic pin;
        logic al;
        logic aas;
        logic ad0;
        logic lrb;
    } i2cra_status_t;
    // master sequencer states
    typedef enum logic [4:0] {
        M_IDLE = 5'h01,
        M_START = 5'h02,
        M_RUN = 5'h04,
        M_HOLD = 5'h08,
        M_STOP = 5'h10
    } i2cra_mstate_t;
endpackage : i2cra_pkg

/* sim/i2cra_partner.sv */
`timescale 1ns/10ps
// far side of the bus: a slave that acks, can stretch scl, and can master
module i2cra_partner (
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_oe_n_out,
    output logic sda_oe_n_out
);
    localparam realtime HALF = 62.5; // half of the 125 ns link period
    logic stretch_en = 1'b0; // hold scl low after each fall
    logic own = 1'b0; // high while this party masters the bus
    logic ack_oe_n = 1'b1; // slave ack driver, low pulls sda
    logic m_sda_oe_n = 1'b1; // master data driver, low pulls sda
    int rises = 0; // scl rises since the last start
    initial scl_oe_n_out = 1'b1;
    // released lines float to the pull-up, never the last value
    assign sda_oe_n_out = ack_oe_n & m_sda_oe_n;
    // a start restarts the bit count
    always @(negedge sda_in) if (scl_in) rises = 0;
    always @(posedge scl_in) rises = rises + 1;
    // ack the ninth bit of every byte
    always @(negedge scl_in) ack_oe_n <= !((rises % 9) == 8);
    // slow slave: hold scl low a while after each fall
    always @(negedge scl_in) if (stretch_en && !own) begin
        scl_oe_n_out = 1'b0;
        #300 scl_oe_n_out = 1'b1;
    end
    // start as a second master, bus assumed idle
    task automatic start_cond();
        // small offset keeps every wire change off the clock edges
        #1 own = 1'b1;
        #HALF m_sda_oe_n = 1'b0;
        #HALF scl_oe_n_out = 1'b0;
    endtask : start_cond
    // eight data bits msb first, ninth clock left to the ack
    task automatic send_byte(input logic [7:0] b);
        #1;
        for (int i = 0; i < 9; i++) begin
            m_sda_oe_n = (i < 8) ? b[7 - i] : 1'b1;
            #HALF scl_oe_n_out = 1'b1;
            #HALF scl_oe_n_out = 1'b0;
        end
    endtask : send_byte
    // stop: sda rises while scl high
    task automatic stop_cond();
        #1 m_sda_oe_n = 1'b0;
        #HALF scl_oe_n_out = 1'b1;
        #HALF m_sda_oe_n = 1'b1;
        #HALF own = 1'b0;
    endtask : stop_cond
endmodule : i2cra_partner

/* sim/test_i2cra_core.sv */
`timescale 1ns/10ps
module test_i2cra_core;
    logic clk = 1'b0; // 200 MHz system clock
    logic rst_n = 1'b0; // async reset, active low
    logic [2:0] bus_addr = 3'h0; // register index
    logic [7:0] bus_wdata = 8'h00; // write data
    logic bus_wr = 1'b0; // write strobe
    logic bus_rd = 1'b0; // read strobe
    logic [7:0] bus_rdata; // read data, one cycle late
    logic [7:0] got; // last read value
    logic d_scl, d_scl_oe_n, d_sda, d_sda_oe_n, p_scl_oe_n, p_sda_oe_n; // pin drivers
    wire scl_w = d_scl_oe_n & p_scl_oe_n; // open drain with pull-up
    wire sda_w = d_sda_oe_n & p_sda_oe_n;
    int fails = 0; // mismatches
    int checks_done = 0; // comparisons made
    int seed = 17457; // fixed seed keeps runs repeatable
    int mon_n = 0; // bits seen since last start
    int stops = 0; // stop conditions seen on the wire
    logic [7:0] mon_sh = 8'h00, mon_byte = 8'h00; // wire byte capture
    logic [7:0] v, a1, a2; // random stimulus
    always #2.5 clk = ~clk;
    // scl of 2 cycles per step keeps the run short
    i2cra_core #(.HALF_UNIT(2)) i_dut (.clk_in(clk), .rst_n_in(rst_n), .addr_in(bus_addr), .wdata_in(bus_wdata),
        .wr_in(bus_wr), .rd_in(bus_rd), .rdata_out(bus_rdata), .scl_in(scl_w), .scl_out(d_scl),
        .scl_oe_n_out(d_scl_oe_n), .sda_in(sda_w), .sda_out(d_sda), .sda_oe_n_out(d_sda_oe_n));
    i2cra_partner i_partner (.scl_in(scl_w), .sda_in(sda_w), .scl_oe_n_out(p_scl_oe_n), .sda_oe_n_out(p_sda_oe_n));
    // wire monitor: start, stop and msb-first byte capture
    always @(negedge sda_w) if (scl_w) mon_n = 0;
    always @(posedge sda_w) if (scl_w) stops++;
    always @(posedge scl_w) begin
        if (mon_n < 8) mon_sh = {mon_sh[6:0], sda_w};
        mon_n++;
        if (mon_n == 8) mon_byte = mon_sh;
    end
    // verdict and end of run, also reached by a timeout
    task automatic final_report();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report
    // one byte write, strobe for a single cycle
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask : wr
    // one byte read, data taken in the cycle after the strobe
    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1 got = bus_rdata;
    endtask : rd
    // write then read back with no gap between the strobes
    task automatic wr_rd(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 1'b0;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1 got = bus_rdata;
    endtask : wr_rd
    // expected readback of a plain register after writing d
    function automatic logic [7:0] exp_read(input logic [2:0] a, input logic [7:0] d);
        if (a == i2cra_pkg::ADDR_CLOCK) return d;
        if (a == i2cra_pkg::ADDR_PORTSEL) return {4'h0, d[3:0]};
        return 8'h00;
    endfunction : exp_read
    // register comparison under a mask
    task automatic chk_reg(input logic [7:0] exp, input logic [7:0] mask);
        checks_done++;
        if ((got & mask) !== (exp & mask)) begin
            fails++;
            $display("[FAIL] %0t reg %0d read %h expected %h", $time, bus_addr, got, exp);
        end
    endtask : chk_reg
    // wire observation comparison
    task automatic chk_wire(input logic [31:0] g, input logic [31:0] exp);
        checks_done++;
        if (g !== exp) begin
            fails++;
            $display("[FAIL] %0t wire saw %h expected %h", $time, g, exp);
        end
    endtask : chk_wire
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] mask);
        rd(a);
        chk_reg(exp, mask);
    endtask : rd_chk
    // poll a status bit, optionally reading shift too, bounded
    task automatic wait_stat(input int n, input logic val, input bit with_shift);
        for (int k = 0; k < 3000; k++) begin
            if (with_shift) rd(i2cra_pkg::ADDR_SHIFT);
            rd(i2cra_pkg::ADDR_STATUS);
            if (got[n] === val) return;
        end
        fails++;
        $display("[FAIL] %0t status wait timed out", $time);
        final_report();
    endtask : wait_stat
    // after a byte, wait until the design holds scl low, bounded
    task automatic wait_hold();
        for (int k = 0; k < 3000; k++) begin
            @(posedge clk);
            if (d_scl_oe_n === 1'b0) return;
        end
        fails++;
        $display("[FAIL] %0t hold wait timed out", $time);
        final_report();
    endtask : wait_hold
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        // reset values, unmapped index included
        for (int i = 0; i < 8; i++) begin
            rd_chk(i[2:0], (i == 2) ? i2cra_pkg::RST_STATUS : i2cra_pkg::RST_ZERO, 8'hFF);
        end
        // readback kinds, corners first then random; clock read straight after its write
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
            wr(i2cra_pkg::ADDR_PORTSEL, v);
            wr(i2cra_pkg::ADDR_TXBUF, v);
            wr(3'h7, v);
            wr_rd(i2cra_pkg::ADDR_CLOCK, v);
            chk_reg(exp_read(i2cra_pkg::ADDR_CLOCK, v), 8'hFF);
            rd_chk(i2cra_pkg::ADDR_PORTSEL, exp_read(i2cra_pkg::ADDR_PORTSEL, v), 8'hFF);
            rd_chk(i2cra_pkg::ADDR_TXBUF, exp_read(i2cra_pkg::ADDR_TXBUF, v), 8'hFF);
            rd_chk(3'h7, exp_read(3'h7, v), 8'hFF);
        end
        wr(i2cra_pkg::ADDR_CLOCK, 8'h04); // slower scl for the sync latency
        // enable, counter preset nonzero, written whole
        wr(i2cra_pkg::ADDR_CONTROL, 8'h0F);
        // whole-byte write, rw bit set
        wr(i2cra_pkg::ADDR_SLAVE, 8'hA5);
        // another master starts, sends a byte, stops
        i_partner.start_cond();
        repeat (10) @(posedge clk);
        rd_chk(i2cra_pkg::ADDR_STATUS, 8'h20, 8'h20);
        rd_chk(i2cra_pkg::ADDR_CONTROL, 8'h00, 8'h07);
        v = 8'($random(seed));
        i_partner.send_byte(v);
        repeat (10) @(posedge clk);
        rd_chk(i2cra_pkg::ADDR_SHIFT, v, 8'hFF);
        rd_chk(i2cra_pkg::ADDR_CONTROL, 8'h00, 8'h07);
        i_partner.stop_cond();
        repeat (10) @(posedge clk);
        rd_chk(i2cra_pkg::ADDR_STATUS, 8'h00, 8'h20);
        rd_chk(i2cra_pkg::ADDR_SLAVE, 8'hA4, 8'hFF);
        // own start: busy test, address, two idle slots, trigger
        rd_chk(i2cra_pkg::ADDR_STATUS, 8'h00, 8'h20);
        a1 = {7'($random(seed)), 1'b0};
        wr(i2cra_pkg::ADDR_SHIFT, a1);
        repeat (2) @(posedge clk);
        wr(i2cra_pkg::ADDR_STATUS, 8'hF0);
        wait_stat(4, 1'b0, 1'b0);
        chk_wire(mon_byte, a1);
        rd_chk(i2cra_pkg::ADDR_STATUS, 8'hE0, 8'hE1);
        // stop and restart triggers only count once the byte has ended
        wait_hold();
        // repeated start through the transmit buffer, slave stretching
        i_partner.stretch_en = 1'b1;
        a2 = 8'($random(seed));
        wr(i2cra_pkg::ADDR_TXBUF, a2);
        repeat (2) @(posedge clk);
        wr(i2cra_pkg::ADDR_STATUS, 8'hF0);
        wait_stat(4, 1'b0, 1'b0);
        chk_wire(mon_byte, a2);
        wait_hold();
        i_partner.stretch_en = 1'b0;
        // stop with reads only until idle; the slave may still hold the last low
        v = 8'(stops);
        wr(i2cra_pkg::ADDR_STATUS, 8'hD0);
        wait_stat(5, 1'b0, 1'b1);
        chk_wire(32'(stops), 32'(v) + 32'h1);
        rd_chk(i2cra_pkg::ADDR_STATUS, 8'h00, 8'hE0);
        // open-drain pins: driven level low, both lines released when idle
        chk_wire(32'({d_scl, d_sda, d_scl_oe_n, d_sda_oe_n}), 32'h3);
        // reset in mid-run brings the registers back
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(i2cra_pkg::ADDR_STATUS, i2cra_pkg::RST_STATUS, 8'hFF);
        rd_chk(i2cra_pkg::ADDR_CLOCK, i2cra_pkg::RST_ZERO, 8'hFF);
        final_report();
    end
endmodule : test_i2cra_core
